//--- touch_scan_result_readout.sv
// Register front end for touch scan results and device commands.
// Assumes a serial slave decodes bus cycles into byte strobes on clk_i,
// and a sensing core supplies per-button results on the same clock.
`timescale 1ns/1ps
`include "touch_readout_map.svh"
module touch_scan_result_readout
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [1:0]  sense_cfg_i,
  input  wire logic        scan_done_i,
  input  wire logic [15:0] base1_i,
  input  wire logic [15:0] diff1_i,
  input  wire logic [15:0] raw1_i,
  input  wire logic [15:0] base2_i,
  input  wire logic [15:0] diff2_i,
  input  wire logic [15:0] raw2_i,
  input  wire logic [1:0]  sensor_on_flags_i,
  output logic      [7:0]  rdata_o,
  output logic             rvalid_o,
  output logic      [7:0]  cmd_o,
  output logic             cmd_valid_o,
  output logic             save_nvm_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic one_hot2(input logic [1:0] m);
    one_hot2 = (m == `MASK_BTN1) || (m == `MASK_BTN2);
  endfunction

  function automatic logic [7:0] hi_byte(input logic [15:0] w);
    hi_byte = w[15:8];
  endfunction

  function automatic logic [7:0] lo_byte(input logic [15:0] w);
    lo_byte = w[7:0];
  endfunction

  // ----------------------------------------------------------------
  // Select register
  // ----------------------------------------------------------------
  logic                   read_en;
  logic [1:0]             button_select_mask;
  touch_readout_pkg::read_mode_t mode;
  logic [15:0]            base_w;
  logic [15:0]            diff_w;
  logic [15:0]            raw_w;
  logic [15:0]            sel_base;
  logic [15:0]            sel_diff;
  logic [15:0]            sel_raw;
  logic                   capture;
  logic [1:0]             sensor_on_flags;
  logic [7:0]             next_rdata;
  logic                   sel_wr;
  logic                   cmd_wr;

  assign sel_wr = wr_i && (addr_i == `ADDR_SELECT);
  assign cmd_wr = wr_i && (addr_i == `ADDR_COMMAND);

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      read_en <= `SEL_EN_RESET;
    else if (sel_wr)
      read_en <= wdata_i[`SEL_EN_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      button_select_mask <= `MASK_NONE;
    else if (sel_wr && one_hot2(wdata_i[`SEL_MASK_F])
             && ((wdata_i[`SEL_MASK_F] & sense_cfg_i) != `MASK_NONE))
      button_select_mask <= wdata_i[`SEL_MASK_F];
  end

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_base = `WORD_ZERO;
    sel_diff = `WORD_ZERO;
    sel_raw  = `WORD_ZERO;
    unique case (button_select_mask)
      `MASK_BTN1:
      begin
        sel_base = base1_i;
        sel_diff = diff1_i;
        sel_raw  = raw1_i;
      end
      `MASK_BTN2:
      begin
        sel_base = base2_i;
        sel_diff = diff2_i;
        sel_raw  = raw2_i;
      end
      default:
      begin
        sel_base = `WORD_ZERO;
        sel_diff = `WORD_ZERO;
        sel_raw  = `WORD_ZERO;
      end
    endcase
  end

  // Capturing only at scan end keeps byte pairs from the same scan
  assign capture = read_en && scan_done_i
                   && (button_select_mask != `MASK_NONE);

  result_capture u_capture
  (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .capture_i (capture),
    .base_i    (sel_base),
    .diff_i    (sel_diff),
    .raw_i     (sel_raw),
    .base_o    (base_w),
    .diff_o    (diff_w),
    .raw_o     (raw_w)
  );

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      sensor_on_flags <= `MASK_NONE;
    else
      sensor_on_flags <= sensor_on_flags_i & sense_cfg_i;
  end

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cmd_o       <= `BYTE_ZERO;
      cmd_valid_o <= 1'b0;
    end
    else
    begin
      cmd_valid_o <= cmd_wr;
      if (cmd_wr)
        cmd_o <= wdata_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      save_nvm_o <= 1'b0;
    else
      save_nvm_o <= cmd_wr && (wdata_i == `OP_SAVE_NVM);
  end

  // Revision byte is served once, then normal decoding resumes
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      mode <= touch_readout_pkg::RD_NORMAL;
    else if (cmd_wr)
      mode <= (wdata_i == `OP_FW_REV) ? touch_readout_pkg::RD_FW_REV
                                       : touch_readout_pkg::RD_NORMAL;
    else if (rd_i)
      mode <= touch_readout_pkg::RD_NORMAL;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb
  begin
    next_rdata = `BYTE_ZERO;
    if (mode == touch_readout_pkg::RD_FW_REV)
      next_rdata = `FW_REV_BYTE;
    else
      unique case (addr_i)
        `ADDR_SELECT:  next_rdata = {read_en, 5'h00, button_select_mask};
        `ADDR_BASE_HI: next_rdata = hi_byte(base_w);
        `ADDR_BASE_LO: next_rdata = lo_byte(base_w);
        `ADDR_DIFF_HI: next_rdata = hi_byte(diff_w);
        `ADDR_DIFF_LO: next_rdata = lo_byte(diff_w);
        `ADDR_RAW_HI:  next_rdata = hi_byte(raw_w);
        `ADDR_RAW_LO:  next_rdata = lo_byte(raw_w);
        `ADDR_STATUS:  next_rdata = {6'h00, sensor_on_flags};
        default:       next_rdata = `BYTE_ZERO;
      endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      rdata_o  <= `BYTE_ZERO;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_i;
      if (rd_i)
        rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  bad_mask_kept_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    sel_wr && !one_hot2(wdata_i[`SEL_MASK_F]) |=> $stable(button_select_mask))
    else $error("mask changed on invalid write");

  unsensed_kept_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    sel_wr && ((wdata_i[`SEL_MASK_F] & sense_cfg_i) == `MASK_NONE)
    |=> $stable(button_select_mask))
    else $error("mask changed to unsensed pin");

  enable_bit_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    sel_wr |=> read_en == $past(wdata_i[`SEL_EN_BIT]))
    else $error("enable bit not taken");

  hold_disabled_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !read_en ##1 !read_en
    |-> $stable(raw_w) && $stable(base_w) && $stable(diff_w))
    else $error("results moved while disabled");

  cmd_strobe_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    cmd_wr |=> cmd_valid_o && cmd_o == $past(wdata_i))
    else $error("command not issued");

  save_cmd_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    save_nvm_o |-> cmd_valid_o && cmd_o == `OP_SAVE_NVM)
    else $error("save without save command");

  fw_rev_read_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    mode == touch_readout_pkg::RD_FW_REV && rd_i
    |=> rvalid_o && rdata_o == `FW_REV_BYTE)
    else $error("revision byte not returned");

  base_hi_read_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    rd_i && mode == touch_readout_pkg::RD_NORMAL
    && addr_i == `ADDR_BASE_HI |=> rdata_o == $past(base_w[15:8]))
    else $error("baseline high byte wrong");

  diff_lo_read_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    rd_i && mode == touch_readout_pkg::RD_NORMAL
    && addr_i == `ADDR_DIFF_LO |=> rdata_o == $past(diff_w[7:0]))
    else $error("difference low byte wrong");

  fw_rev_arm_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    cmd_wr && wdata_i == `OP_FW_REV
    |=> mode == touch_readout_pkg::RD_FW_REV)
    else $error("revision read not armed");

  fw_rev_once_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    mode == touch_readout_pkg::RD_FW_REV && rd_i && !cmd_wr
    |=> mode == touch_readout_pkg::RD_NORMAL)
    else $error("revision served twice");

  whole_capture_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    capture |=> base_w == $past(sel_base) && diff_w == $past(sel_diff)
    && raw_w == $past(sel_raw))
    else $error("result words not captured together");

  status_read_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    rd_i && mode == touch_readout_pkg::RD_NORMAL && addr_i == `ADDR_STATUS
    |=> rdata_o == {6'h00, $past(sensor_on_flags)})
    else $error("status byte wrong");

  raw_hi_read_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    rd_i && mode == touch_readout_pkg::RD_NORMAL
    && addr_i == `ADDR_RAW_HI |=> rdata_o == $past(raw_w[15:8]))
    else $error("raw count high byte wrong");

  select_btn1_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    sel_wr && wdata_i[`SEL_MASK_F] == `MASK_BTN1
    && (sense_cfg_i & `MASK_BTN1) != `MASK_NONE
    |=> button_select_mask == `MASK_BTN1)
    else $error("button 1 not selected");

  select_btn2_a: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    sel_wr && wdata_i[`SEL_MASK_F] == `MASK_BTN2
    && (sense_cfg_i & `MASK_BTN2) != `MASK_NONE
    |=> button_select_mask == `MASK_BTN2)
    else $error("button 2 not selected");
endmodule

//--- touch_readout_map.svh
// Register map, field positions, reset values and opcodes of the readout.
// Assumes inclusion by bare name from the design files.
`ifndef TOUCH_READOUT_MAP_SVH
`define TOUCH_READOUT_MAP_SVH
// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define ADDR_SELECT     8'h81
`define ADDR_BASE_HI    8'h82
`define ADDR_BASE_LO    8'h83
`define ADDR_DIFF_HI    8'h84
`define ADDR_DIFF_LO    8'h85
`define ADDR_RAW_HI     8'h86
`define ADDR_RAW_LO     8'h87
`define ADDR_STATUS     8'h88
`define ADDR_COMMAND    8'ha0
// ----------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------
`define SEL_EN_BIT      7
`define SEL_MASK_F      1:0
`define SEL_RESET       8'h00
`define SEL_EN_RESET    1'b0
`define MASK_BTN1       2'h1
`define MASK_BTN2       2'h2
`define MASK_NONE       2'h0
`define BYTE_ZERO       8'h00
`define WORD_ZERO       16'h0000
`define OP_FW_REV       8'h00
`define OP_SAVE_NVM     8'h01
`define FW_REV_BYTE     8'h10
`endif

//--- touch_readout_pkg.sv
// Types shared by the readout design.
// Assumes the map header for numeric values.
package touch_readout_pkg;
  typedef enum logic [1:0] {
    RD_NORMAL,
    RD_FW_REV
  } read_mode_t;
endpackage

//--- result_capture.sv
// Coherent capture of the three 16-bit results of one input.
// Assumes the sensing core presents a one-cycle scan_done pulse per scan.
`timescale 1ns/1ps
`include "touch_readout_map.svh"
module result_capture
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        capture_i,
  input  wire logic [15:0] base_i,
  input  wire logic [15:0] diff_i,
  input  wire logic [15:0] raw_i,
  output logic      [15:0] base_o,
  output logic      [15:0] diff_o,
  output logic      [15:0] raw_o
);
  // Whole words load together so high and low bytes stay paired
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      base_o <= `WORD_ZERO;
      diff_o <= `WORD_ZERO;
      raw_o  <= `WORD_ZERO;
    end
    else if (capture_i)
    begin
      base_o <= base_i;
      diff_o <= diff_i;
      raw_o  <= raw_i;
    end
  end
endmodule

//--- host_model.sv
// Host side model issuing byte writes and reads to the readout.
// Assumes rvalid_i answers a read strobe one cycle later.
`timescale 1ns/1ps
module host_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  // ----------------------------------------------------------------
  // Byte transfers
  // ----------------------------------------------------------------
  initial
  begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end
  // Released lines flip, so a stale value never looks fresh
  task automatic release_bus();
    addr_o  = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_o    = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    release_bus();
  endtask
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d,
                           output logic ok);
    @(posedge clk_i);
    #1;
    rd_o   = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    ok = rvalid_i;
    d  = rdata_i;
    rd_o = 1'b0;
    release_bus();
  endtask
endmodule

//--- touch_scan_result_readout_test.sv
// Self-checking bench for the touch scan result readout.
// Assumes host_model drives the byte strobes; bench drives the core side.
`timescale 1ns/1ps
`include "touch_readout_map.svh"
module touch_scan_result_readout_test;
  typedef struct packed {logic [7:0] sel; logic [7:0] a; logic [7:0] e;} row_t;
  localparam int N_ROWS = 15;
  logic        clk_i, nrst_i, wr_i, rd_i, scan_done_i, rvalid_o;
  logic        cmd_valid_o, save_nvm_o, ok;
  logic [7:0]  addr_i, wdata_i, rdata_o, cmd_o, got;
  logic [1:0]  sense_cfg_i, sensor_on_flags_i;
  logic [15:0] base1_i, diff1_i, raw1_i, base2_i, diff2_i, raw2_i;
  int          errors, n_tests, cycles;
  row_t rows [N_ROWS] = '{
    '{8'h81, 8'h82, 8'h12}, '{8'h81, 8'h83, 8'h34}, '{8'h81, 8'h84, 8'h56},
    '{8'h81, 8'h85, 8'h78}, '{8'h81, 8'h86, 8'h9a}, '{8'h81, 8'h87, 8'hbc},
    '{8'h82, 8'h82, 8'hde}, '{8'h82, 8'h85, 8'h57}, '{8'h82, 8'h87, 8'h68},
    '{8'h82, 8'h81, 8'h82}, '{8'h03, 8'h81, 8'h02}, '{8'h00, 8'h81, 8'h02},
    '{8'h81, 8'h88, 8'h02}, '{8'h81, 8'h90, 8'h00}, '{8'h81, 8'ha0, 8'h00}};
  host_model i_host (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i));
  touch_scan_result_readout i_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .sense_cfg_i(sense_cfg_i), .scan_done_i(scan_done_i),
    .base1_i(base1_i), .diff1_i(diff1_i), .raw1_i(raw1_i),
    .base2_i(base2_i), .diff2_i(diff2_i), .raw2_i(raw2_i),
    .sensor_on_flags_i(sensor_on_flags_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o),
    .save_nvm_o(save_nvm_o));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.read_byte(a, got, ok);
    chk({7'h00, ok}, 8'h01);
    chk(got, e);
  endtask
  task automatic scan();
    @(posedge clk_i);
    #1 scan_done_i = 1'b1;
    @(posedge clk_i);
    #1 scan_done_i = 1'b0;
  endtask
  task automatic cmd_chk(input logic [7:0] op, input logic sv);
    i_host.write_byte(`ADDR_COMMAND, op);
    chk({7'h00, cmd_valid_o}, 8'h01);
    chk({7'h00, save_nvm_o}, {7'h00, sv});
    chk(cmd_o, op);
    @(posedge clk_i);
    #1;
    chk({6'h00, cmd_valid_o, save_nvm_o}, 8'h00);
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst_i = 1'b0;
    scan_done_i = 1'b0;
    sense_cfg_i = 2'h3;
    sensor_on_flags_i = 2'h2;
    base1_i = 16'h1234;
    diff1_i = 16'h5678;
    raw1_i = 16'h9abc;
    base2_i = 16'hdef0;
    diff2_i = 16'h1357;
    raw2_i = 16'h2468;
    repeat (4) @(posedge clk_i);
    #1 nrst_i = 1'b1;
    for (int i = 0; i < N_ROWS; i++)
    begin
      i_host.write_byte(`ADDR_SELECT, rows[i].sel);
      scan();
      rd_chk(rows[i].a, rows[i].e);
    end
    // Button 2 not sensing: mask kept, enable still taken
    sense_cfg_i = 2'h1;
    i_host.write_byte(`ADDR_SELECT, 8'h82);
    rd_chk(`ADDR_SELECT, 8'h81);
    rd_chk(`ADDR_STATUS, 8'h00);
    i_host.write_byte(`ADDR_SELECT, 8'h01);
    base1_i = 16'haa55;
    scan();
    rd_chk(`ADDR_BASE_HI, 8'h12);
    i_host.write_byte(`ADDR_SELECT, 8'h81);
    scan();
    base1_i = 16'h0000;
    i_host.write_byte(`ADDR_BASE_HI, 8'h77);
    rd_chk(`ADDR_BASE_HI, 8'haa);
    rd_chk(`ADDR_BASE_LO, 8'h55);
    cmd_chk(`OP_FW_REV, 1'b0);
    rd_chk(`ADDR_DIFF_HI, `FW_REV_BYTE);
    rd_chk(`ADDR_DIFF_HI, 8'h56);
    cmd_chk(`OP_SAVE_NVM, 1'b1);
    cmd_chk(8'h05, 1'b0);
    i_host.write_byte(`ADDR_COMMAND, `OP_FW_REV);
    // Second reset in mid-run
    @(posedge clk_i);
    #1 nrst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk(cmd_o, 8'h00);
    chk(rdata_o, `BYTE_ZERO);
    chk({5'h00, cmd_valid_o, rvalid_o, save_nvm_o}, 8'h00);
    nrst_i = 1'b1;
    rd_chk(`ADDR_SELECT, `SEL_RESET);
    rd_chk(`ADDR_DIFF_LO, `BYTE_ZERO);
    give_verdict();
  end
endmodule
